// >>> verilog/relative_branch_pkg.sv
package relative_branch_pkg;

    // Branch opcodes of the relative branch group
    localparam logic [7:0] OP_BRANCH_ALWAYS            = 8'h20;
    localparam logic [7:0] OP_BRANCH_NEVER             = 8'h21;
    localparam logic [7:0] OP_BRANCH_HIGHER            = 8'h22;
    localparam logic [7:0] OP_BRANCH_LOWER_OR_SAME     = 8'h23;
    localparam logic [7:0] OP_BRANCH_HIGHER_OR_SAME    = 8'h24;
    localparam logic [7:0] OP_BRANCH_LOWER             = 8'h25;
    localparam logic [7:0] OP_BRANCH_NOT_EQUAL         = 8'h26;
    localparam logic [7:0] OP_BRANCH_EQUAL             = 8'h27;
    localparam logic [7:0] OP_BRANCH_HALF_CARRY_CLEAR  = 8'h28;
    localparam logic [7:0] OP_BRANCH_HALF_CARRY_SET    = 8'h29;
    localparam logic [7:0] OP_BRANCH_PLUS              = 8'h2A;
    localparam logic [7:0] OP_BRANCH_MINUS             = 8'h2B;
    localparam logic [7:0] OP_BRANCH_MASK_CLEAR        = 8'h2C;
    localparam logic [7:0] OP_BRANCH_MASK_SET          = 8'h2D;
    localparam logic [7:0] OP_BRANCH_IRQ_PIN_LOW       = 8'h2E;
    localparam logic [7:0] OP_BRANCH_IRQ_PIN_HIGH      = 8'h2F;

    // Length of a relative branch instruction in bytes
    localparam logic [15:0] BRANCH_LENGTH = 16'h0002;

    // APB register byte addresses
    localparam logic [11:0] ADDR_CONTROL     = 12'h000;
    localparam logic [11:0] ADDR_STATUS      = 12'h004;
    localparam logic [11:0] ADDR_TAKEN_COUNT = 12'h008;
    localparam logic [11:0] ADDR_LAST_TARGET = 12'h00C;

    // Field positions
    localparam int CONTROL_ENABLE_BIT  = 0;
    localparam int STATUS_BUSY_BIT     = 0;
    localparam int STATUS_BAD_OP_BIT   = 1;
    localparam int STATUS_TAKEN_BIT    = 2;
    localparam int STATUS_OPCODE_LSB   = 8;

    localparam logic        ENABLE_RESET = 1'b1;
    localparam logic [31:0] TAKEN_COUNT_ONE = 32'h0000_0001;

    typedef logic [15:0] addr_t;

    typedef struct packed {
        logic half_carry;
        logic irq_mask;
        logic negative;
        logic zero;
        logic carry;
    } ccr_flags_t;

    typedef struct packed {
        logic [7:0] opcode;
        addr_t      opcode_addr;
        logic [7:0] offset;
    } branch_req_t;

    typedef struct packed {
        logic  taken;
        addr_t pc_next;
    } branch_result_t;

    typedef struct packed {
        logic [11:0] paddr;
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_EVAL   = 3'b010,
        ST_COMMIT = 3'b100
    } seq_state_t;

endpackage

// >>> verilog/branch_condition_eval.sv
`timescale 1ns/1ps
`default_nettype none

module branch_condition_eval
    import relative_branch_pkg::*;
(
    // Instruction and condition inputs
    input  wire logic [7:0] opcode,
    input  wire ccr_flags_t flags,
    input  wire logic       irq_pin,
    // Decode result
    output logic            is_branch,
    output logic            taken
);

    // Flags are only read here, never written
    always_comb begin
        is_branch = 1'b1;
        taken     = 1'b0;
        unique case (opcode)
            OP_BRANCH_ALWAYS:           taken = 1'b1;
            OP_BRANCH_NEVER:            taken = 1'b0;
            OP_BRANCH_HIGHER:           taken = (flags.carry | flags.zero) == 1'b0;
            OP_BRANCH_LOWER_OR_SAME:    taken = (flags.carry | flags.zero) == 1'b1;
            OP_BRANCH_HIGHER_OR_SAME:   taken = flags.carry == 1'b0;
            OP_BRANCH_LOWER:            taken = flags.carry;
            OP_BRANCH_NOT_EQUAL:        taken = ~flags.zero;
            OP_BRANCH_EQUAL:            taken = flags.zero;
            OP_BRANCH_HALF_CARRY_CLEAR: taken = ~flags.half_carry;
            OP_BRANCH_HALF_CARRY_SET:   taken = flags.half_carry;
            OP_BRANCH_PLUS:             taken = ~flags.negative;
            OP_BRANCH_MINUS:            taken = flags.negative;
            OP_BRANCH_MASK_CLEAR:       taken = ~flags.irq_mask;
            OP_BRANCH_MASK_SET:         taken = flags.irq_mask == 1'b1;
            OP_BRANCH_IRQ_PIN_LOW:      taken = ~irq_pin;
            OP_BRANCH_IRQ_PIN_HIGH:     taken = irq_pin;
            default:                    is_branch = 1'b0;
        endcase
    end

endmodule

`default_nettype wire

// >>> verilog/relative_branch_unit.sv
`timescale 1ns/1ps
`default_nettype none

module relative_branch_unit
    import relative_branch_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Fetch sequencer side
    input  wire logic        start,
    input  wire branch_req_t req,
    input  wire ccr_flags_t  flags,
    input  wire logic        irq_pin,
    output logic             ready,
    output logic             done,
    output branch_result_t   result
);

    typedef struct packed {
        seq_state_t     st;
        branch_req_t    req;
        logic           taken;
        branch_result_t result;
        logic           enable;
        logic           bad_opcode;
        logic [31:0]    taken_count;
        logic [31:0]    rdata;
        logic           err;
    } unit_state_t;

    localparam unit_state_t STATE_RESET = '{
        st:          ST_IDLE,
        req:         '0,
        taken:       1'b0,
        result:      '0,
        enable:      ENABLE_RESET,
        bad_opcode:  1'b0,
        taken_count: '0,
        rdata:       '0,
        err:         1'b0
    };

    unit_state_t state;
    unit_state_t next_state;
    logic        dec_is_branch;
    logic        dec_taken;
    logic        busy;
    logic        accept;
    logic        refuse;
    addr_t       target;
    addr_t       fall_through;
    addr_t       pc_next_value;
    logic [31:0] count_step;
    logic [31:0] status_word;
    logic [31:0] read_word;
    logic        apb_setup;
    logic        apb_write;
    logic        sel_control;
    logic        sel_status;
    logic        sel_taken_count;
    logic        sel_last_target;
    logic        addr_hit;
    logic        write_control;
    logic        clear_bad_opcode;
    logic        clear_count;

    // Condition flags are sampled in the start cycle; no flag output exists
    branch_condition_eval u_eval (
        .opcode    (req.opcode),
        .flags     (flags),
        .irq_pin   (irq_pin),
        .is_branch (dec_is_branch),
        .taken     (dec_taken)
    );

    // A new branch is taken only while idle and enabled
    assign busy    = state.st != ST_IDLE;
    assign ready   = state.enable & ~busy;
    assign accept  = start & ready & dec_is_branch;
    // Opcodes outside the branch group are dropped but remembered
    assign refuse  = start & ready & ~dec_is_branch;
    assign done    = state.st == ST_COMMIT;
    assign result  = state.result;

    // Offset is sign extended from the last instruction byte
    assign fall_through  = state.req.opcode_addr + BRANCH_LENGTH;
    assign target        = fall_through + {{8{state.req.offset[7]}}, state.req.offset};
    // A branch that falls through still steps over its offset byte
    assign pc_next_value = state.taken ? target : fall_through;
    assign count_step    = state.taken ? TAKEN_COUNT_ONE : '0;

    // Register decode: each register is one aligned word
    assign sel_control     = paddr == ADDR_CONTROL;
    assign sel_status      = paddr == ADDR_STATUS;
    assign sel_taken_count = paddr == ADDR_TAKEN_COUNT;
    assign sel_last_target = paddr == ADDR_LAST_TARGET;
    assign addr_hit        = sel_control | sel_status | sel_taken_count | sel_last_target;

    // Writes act in the access phase; an unmapped address writes nothing
    assign apb_setup        = psel & ~penable;
    assign apb_write        = psel & penable & pwrite & ~state.err;
    assign write_control    = apb_write & sel_control;
    assign clear_bad_opcode = apb_write & sel_status & pwdata[STATUS_BAD_OP_BIT];
    assign clear_count      = apb_write & sel_taken_count;

    always_comb begin
        status_word = '0;
        status_word[STATUS_BUSY_BIT]   = busy;
        status_word[STATUS_BAD_OP_BIT] = state.bad_opcode;
        status_word[STATUS_TAKEN_BIT]  = state.result.taken;
        status_word[STATUS_OPCODE_LSB +: 8] = state.req.opcode;
    end

    // Read data is chosen in the setup cycle and held through the access
    always_comb begin
        read_word = '0;
        if (sel_control) begin
            read_word[CONTROL_ENABLE_BIT] = state.enable;
        end
        if (sel_status) begin
            read_word = status_word;
        end
        if (sel_taken_count) begin
            read_word = state.taken_count;
        end
        if (sel_last_target) begin
            read_word = {16'h0000, state.result.pc_next};
        end
    end

    always_comb begin
        next_state = state;

        unique case (state.st)
            ST_IDLE: begin
                if (accept) begin
                    next_state.req   = req;
                    next_state.taken = dec_taken;
                    next_state.st    = ST_EVAL;
                end
            end
            ST_EVAL: begin
                // Target or fall-through address, third cycle reports it
                next_state.result.taken   = state.taken;
                next_state.result.pc_next = pc_next_value;
                next_state.taken_count    = state.taken_count + count_step;
                next_state.st             = ST_COMMIT;
            end
            ST_COMMIT: begin
                next_state.st = ST_IDLE;
            end
        endcase

        // APB: read data and error are captured in the setup cycle
        if (apb_setup) begin
            next_state.err   = ~addr_hit;
            next_state.rdata = pwrite ? '0 : read_word;
        end

        // Enable low holds off new branches; one in flight still finishes
        if (write_control) begin
            next_state.enable = pwdata[CONTROL_ENABLE_BIT];
        end
        if (clear_bad_opcode) begin
            next_state.bad_opcode = 1'b0;
        end
        // Any write to the taken count clears it, also in the cycle of a taken branch
        if (clear_count) begin
            next_state.taken_count = '0;
        end

        // A refused opcode sets the sticky flag; set wins over a clear
        if (refuse) begin
            next_state.bad_opcode = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= STATE_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign prdata  = state.rdata;
    assign pready  = 1'b1;
    assign pslverr = psel & penable & state.err;

endmodule

`default_nettype wire

// >>> bench/relative_branch_unit_checker.sv
`timescale 1ns/1ps
`default_nettype none
module relative_branch_unit_checker
    import relative_branch_pkg::*;
(
    // Watched ports
    input wire logic           pclk,
    input wire logic           presetn,
    input wire logic           start,
    input wire branch_req_t    req,
    input wire ccr_flags_t     flags,
    input wire logic           ready,
    input wire logic           done,
    input wire branch_result_t result
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Taken decision of one opcode against the flag it tests
    property cond_p(logic [7:0] op, logic want);
        done && $past(req.opcode, 2) == op |-> result.taken == want;
    endproperty
    a_busy_then_done: assert property (
        start && ready && req.opcode[7:4] == 4'h2 |=> !ready ##1 (done && !ready))
        else $error("branch not finished in its third cycle");
    a_done_pulse: assert property (done |=> !done)
        else $error("done longer than one cycle");
    a_taken_target: assert property (done && result.taken |-> result.pc_next ==
        $past(req.opcode_addr, 2) + BRANCH_LENGTH + {{8{$past(req.offset[7], 2)}}, $past(req.offset, 2)})
        else $error("taken target wrong");
    a_fall_through: assert property (done && !result.taken |->
        result.pc_next == $past(req.opcode_addr, 2) + BRANCH_LENGTH) else $error("fall address wrong");
    a_always_taken: assert property (cond_p(OP_BRANCH_ALWAYS, 1'b1))
        else $error("always branch not taken");
    a_mask_set: assert property (cond_p(OP_BRANCH_MASK_SET, $past(flags.irq_mask, 2)))
        else $error("mask set branch wrong");
    a_not_equal: assert property (cond_p(OP_BRANCH_NOT_EQUAL, !$past(flags.zero, 2)))
        else $error("not equal branch wrong");
    a_plus_test: assert property (cond_p(OP_BRANCH_PLUS, !$past(flags.negative, 2)))
        else $error("plus branch wrong");
    a_higher_test: assert property (cond_p(OP_BRANCH_HIGHER,
        !($past(flags.carry, 2) || $past(flags.zero, 2)))) else $error("higher branch wrong");
    cover property (done && result.taken);
    cover property (done && !result.taken);
    cover property (start && !ready);
endmodule
bind relative_branch_unit relative_branch_unit_checker i_relative_branch_unit_checker (
    .pclk(pclk), .presetn(presetn), .start(start), .req(req), .flags(flags),
    .ready(ready), .done(done), .result(result));
`default_nettype wire

// >>> bench/relative_branch_unit_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module relative_branch_unit_tb_top
    import relative_branch_pkg::*;
;
    logic           pclk = 1'b0;
    logic           presetn, psel, penable, pwrite, pready, pslverr, e;
    logic           start, irq_pin, ready, done;
    logic [11:0]    paddr;
    logic [31:0]    pwdata, prdata, rd;
    branch_req_t    req;
    ccr_flags_t     flags;
    branch_result_t result;
    int             n_fail, check_count, taken_n;
    always #2 pclk = ~pclk;
    relative_branch_unit i_relative_branch_unit (.pclk(pclk), .presetn(presetn),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .start(start), .req(req),
        .flags(flags), .irq_pin(irq_pin), .ready(ready), .done(done), .result(result));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic conclude;
        $display("checks=%0d failures=%0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 16; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (k == 16) begin
            n_fail++;
            conclude();
        end
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic exp_taken(input logic [7:0] op, input logic [4:0] f, input logic p);
        logic [7:0] c;
        c = {p, f[3], f[2], f[4], f[1], f[0], f[0] | f[1], 1'b0};
        return op[0] ? c[op[3:1]] : !c[op[3:1]];
    endfunction
    task automatic br(input logic [7:0] op, input logic [15:0] a, input logic [7:0] off,
                      input logic [4:0] f, input logic p);
        logic        t;
        logic [15:0] want;
        int          k;
        t = exp_taken(op, f, p);
        want = a + BRANCH_LENGTH + (t ? {{8{off[7]}}, off} : 16'h0000);
        @(posedge pclk);
        start <= 1'b1;
        req <= '{op, a, off};
        flags <= f;
        irq_pin <= p;
        for (k = 0; k < 32; k++) begin
            @(negedge pclk);
            if (ready === 1'b1) break;
        end
        if (k == 32) begin
            n_fail++;
            conclude();
        end
        @(posedge pclk);
        start <= 1'b0;
        for (k = 0; k < 32; k++) begin
            @(negedge pclk);
            if (done === 1'b1) break;
        end
        if (k == 32) begin
            n_fail++;
            conclude();
        end
        chk(result.taken, t);
        chk(result.pc_next, want);
        taken_n += t;
    endtask
    task automatic opcode_sweep;
        logic [4:0] pats [4] = '{5'h00, 5'h1F, 5'h0A, 5'h15};
        for (int op = 8'h20; op <= 8'h2F; op++) begin
            for (int j = 0; j < 4; j++) begin
                br(op[7:0], 16'h1230 + op[15:0], 8'hF0 + j[7:0], pats[j], j[0]);
            end
        end
        br(OP_BRANCH_ALWAYS, 16'hFFFE, 8'h7F, 5'h00, 1'b0);
        br(OP_BRANCH_ALWAYS, 16'h0000, 8'h80, 5'h00, 1'b0);
    endtask
    task automatic refusals;
        apb(1'b1, ADDR_CONTROL, 32'h0);
        @(posedge pclk);
        start <= 1'b1;
        req <= '{OP_BRANCH_ALWAYS, 16'h1000, 8'h00};
        repeat (6) begin
            @(negedge pclk);
            chk({ready, done}, 32'h0);
        end
        @(posedge pclk);
        start <= 1'b0;
        apb(1'b1, ADDR_CONTROL, 32'h1);
        start <= 1'b1;
        req <= '{8'h30, 16'h1000, 8'h00};
        @(posedge pclk);
        start <= 1'b0;
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd[STATUS_BAD_OP_BIT], 32'h1);
        apb(1'b1, ADDR_STATUS, 32'h2);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd[STATUS_BAD_OP_BIT], 32'h0);
        apb(1'b0, 12'h010, 32'h0);
        chk({e, rd[0]}, 32'h2);
    endtask
    task automatic counters;
        apb(1'b0, ADDR_LAST_TARGET, 32'h0);
        chk(rd, 32'h0000_FF82);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd, 32'h0000_2004);
        apb(1'b0, ADDR_TAKEN_COUNT, 32'h0);
        chk(rd, taken_n);
        apb(1'b1, ADDR_TAKEN_COUNT, 32'h5);
        apb(1'b0, ADDR_TAKEN_COUNT, 32'h0);
        chk(rd, 32'h0);
    endtask
    initial begin
        {presetn, psel, penable, pwrite, start, irq_pin} = '0;
        {paddr, pwdata, req, flags} = '0;
        {n_fail, check_count, taken_n} = '0;
        repeat (4) @(posedge pclk);
        chk({ready, done, pready, pslverr}, 32'hA);
        chk(prdata, 32'h0);
        presetn <= 1'b1;
        apb(1'b0, ADDR_CONTROL, 32'h0);
        chk(rd[CONTROL_ENABLE_BIT], 32'h1);
        opcode_sweep();
        counters();
        refusals();
        conclude();
    end
endmodule
`default_nettype wire
